// file: sfr_bank.sv
// Special function register bank with AXI4-Lite slave
// Contract
// R1 - Program memory size field reports none, 32K, 64K, 128K or 256K codes.
// R2 - Data nonvolatile size field always reports zero.
// R3 - Volatile size field reports none, 1K, 2K, 4K or 8K codes.
// R4 - Architecture field is a hardwired two digit BCD family code.
// R5 - Memory type field is a hardwired series code, never reserved.
// R6 - Extension flag reads 0 unless an extended identification exists.
// R7 - Extension word at 0x04 is read-only, hardwired, undefined content.
// R8 - Reset cause reads 0x6C after pin reset, 0x53 after watchdog reset.
// R9 - Permit bit 0 aborts extended RAM writes; 1 lets them complete.
// R10 - Protect register write needs key 0x27A8 in bits 31..16; key reads zero.
// R11 - Protect bit 5 selects interrupt controller protect mode; resets to 0.
// R12 - Memory mode register exists only on the variant with extended RAM.
// R13 - Version field starts at zero, increments per silicon version, max 31.
// R14 - Reserved bits read zero; identification fields placed from bit 31 down.
// R15 - Reset cause changes only at reset; bus accesses leave it alone.
`timescale 1ns/1ps
module sfr_bank #(
    parameter logic [2:0]  MEM_TYPE     = sfr_pkg::SFR_TYPE_SERIES_A,
    parameter logic [7:0]  ARCHITECTURE_CODE_CODE    = 8'h12,
    parameter logic [3:0]  PROG_SIZE    = sfr_pkg::SFR_PSIZE_32K,
    parameter logic [3:0]  RAM_SIZE     = sfr_pkg::SFR_VSIZE_8K,
    parameter logic [4:0]  VERSION      = 5'h00,
    parameter logic        ID_EXTENDED  = 1'b0,
    parameter logic [31:0] ID_EXT_WORD  = 32'h0000_0000,
    parameter logic        HAS_EXT_RAM  = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        watchdog_reset,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Extended RAM write check and interrupt controller protect output
    input  wire logic        ram_write_req,
    output logic             ram_write_abort,
    output logic             irq_controller_protect
);
    import sfr_pkg::*;

    // ==========================================================
    // Identification word
    sfr_chip_id_t chip_id;
    logic [4:0]   version_c;
    logic [3:0]   psize_c;
    logic [3:0]   vsize_c;
    logic [2:0]   type_c;

    // Codes outside the legal sets collapse to none rather than a reserved value
    function automatic logic [3:0] legal_psize(input logic [3:0] c);
        case (c)
            SFR_PSIZE_32K, SFR_PSIZE_64K, SFR_PSIZE_128K, SFR_PSIZE_256K: legal_psize = c;
            default: legal_psize = SFR_PSIZE_NONE;
        endcase
    endfunction

    function automatic logic [3:0] legal_vsize(input logic [3:0] c);
        case (c)
            SFR_VSIZE_1K, SFR_VSIZE_2K, SFR_VSIZE_4K, SFR_VSIZE_8K: legal_vsize = c;
            default: legal_vsize = SFR_VSIZE_NONE;
        endcase
    endfunction

    // Reserved memory type codes fall back to the first series code
    function automatic logic [2:0] legal_type(input logic [2:0] c);
        case (c)
            SFR_TYPE_SERIES_A, SFR_TYPE_SERIES_B: legal_type = c;
            default: legal_type = SFR_TYPE_SERIES_A;
        endcase
    endfunction

    // Key needs both upper lanes and the control lane; a partial key never matches
    function automatic logic key_ok(input logic [31:0] d, input logic [3:0] s);
        key_ok = s[3] && s[2] && s[0] &&
                 d[SFR_KEY_LSB +: $bits(SFR_PROTECT_KEY)] == SFR_PROTECT_KEY;
    endfunction

    // Every field is a constant, so the word costs no flip-flops
    always_comb begin
        psize_c   = legal_psize(PROG_SIZE);                               // R1
        vsize_c   = legal_vsize(RAM_SIZE);                                // R3
        type_c    = legal_type(MEM_TYPE);                                 // R5
        version_c = (VERSION > SFR_VERSION_MAX) ? SFR_VERSION_MAX : VERSION; // R13
        chip_id.id_extension_flag   = ID_EXTENDED;                        // R6
        chip_id.program_memory_type = type_c;
        chip_id.architecture_code   = ARCHITECTURE_CODE_CODE;                          // R4
        chip_id.volatile_ram_size   = vsize_c;
        chip_id.data_nvm_size       = SFR_DSIZE_NONE;                     // R2
        chip_id.program_nvm_size    = psize_c;                            // R14
        chip_id.fixed_pattern       = SFR_ID_PATTERN;
        chip_id.version             = version_c;
    end

    // ==========================================================
    // Reset cause capture
    // The watchdog request comes from another block; synchronise it
    logic       wd_meta_q;
    logic       wd_sync_q;
    logic       first_q;
    logic       first_d;
    logic [7:0] cause_q;
    logic [7:0] cause_d;

    always_comb begin
        first_d = 1'b0;
        cause_d = cause_q;
        if (first_q) begin
            cause_d = wd_sync_q ? SFR_CAUSE_WATCHDOG : SFR_CAUSE_PIN;     // R8 R15
        end
    end

    // The synchroniser has no reset so it keeps tracking the request while
    // the bank is held in reset; the watchdog holds its request across the
    // release, and the cause is taken on the first edge after it
    always_ff @(posedge sys_clk) begin
        wd_meta_q <= watchdog_reset;
        wd_sync_q <= wd_meta_q;
    end

    // Only the first edge after release loads the cause, so bus traffic
    // and later watchdog pulses never disturb it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            first_q <= 1'b1;
            cause_q <= SFR_CAUSE_PIN;
        end else begin
            first_q <= first_d;
            cause_q <= cause_d;
        end
    end

    // ==========================================================
    // Control registers and AXI4-Lite write path
    logic       permit_q;
    logic       permit_d;
    logic       protect_q;
    logic       protect_d;
    logic       aw_held_q;
    logic       aw_held_d;
    logic [7:0] aw_addr_q;
    logic [7:0] aw_addr_d;
    logic       w_held_q;
    logic       w_held_d;
    logic [31:0] w_data_q;
    logic [31:0] w_data_d;
    logic [3:0] w_strb_q;
    logic [3:0] w_strb_d;
    logic       bvalid_q;
    logic       bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic       do_write;

    // One write in flight: both ready lines drop while the response waits,
    // which keeps a second write from overtaking the first
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_comb begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d  = w_held_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        permit_d  = permit_q;
        protect_d = protect_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        do_write = aw_held_q && w_held_q;
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = SFR_RESP_OKAY;
            case (aw_addr_q)
                SFR_OFF_MEM_MODE: begin
                    if (HAS_EXT_RAM) begin                                // R12
                        if (w_strb_q[0]) begin
                            permit_d = w_data_q[SFR_PERMIT_BIT];
                        end
                    end else begin
                        bresp_d = SFR_RESP_SLVERR;
                    end
                end
                SFR_OFF_PROTECT: begin
                    if (key_ok(w_data_q, w_strb_q)) begin                 // R10
                        protect_d = w_data_q[SFR_PROTECT_BIT];            // R11
                    end
                end
                // Read-only words accept the write and drop it
                SFR_OFF_CHIP_ID, SFR_OFF_ID_EXT, SFR_OFF_RST: begin
                    bresp_d = SFR_RESP_OKAY;                              // R15
                end
                default: bresp_d = SFR_RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= SFR_RESP_OKAY;
            // Registers come up locked and in normal mode
            permit_q  <= SFR_PERMIT_RESET;                                // R9
            protect_q <= SFR_PROTECT_RESET;                               // R11
        end else begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            permit_q  <= permit_d;
            protect_q <= protect_d;
        end
    end

    // Without the extended RAM there is nothing to protect, so never abort
    assign ram_write_abort        = HAS_EXT_RAM && ram_write_req && !permit_q; // R9
    assign irq_controller_protect = protect_q;                            // R11

    // ==========================================================
    // AXI4-Lite read path
    sfr_rd_t    rd_c;
    logic       rvalid_q;
    logic       rvalid_d;
    sfr_rd_t    rd_q;
    sfr_rd_t    rd_d;

    sfr_decode u_decode (
        .addr        (s_axi_araddr),
        .chip_id     (chip_id),
        .id_ext      (ID_EXT_WORD),
        .cause       (cause_q),
        .permit      (permit_q),
        .protect     (protect_q),
        .has_ext_ram (HAS_EXT_RAM),
        .rd          (rd_c)
    );

    // Read data is registered at the address handshake, so a read that
    // races a write shows the value from before that write lands
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rd_q.data;
    assign s_axi_rresp   = rd_q.resp;

    always_comb begin
        rvalid_d = rvalid_q;
        rd_d     = rd_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rd_d     = rd_c;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rd_q     <= '{data: 32'h0000_0000, resp: SFR_RESP_OKAY};
        end else begin
            rvalid_q <= rvalid_d;
            rd_q     <= rd_d;
        end
    end

endmodule

// file: sfr_pkg.sv
// Package of constants and types for the special function register bank
package sfr_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] SFR_OFF_CHIP_ID  = 8'h00;
    localparam logic [7:0] SFR_OFF_ID_EXT   = 8'h04;
    localparam logic [7:0] SFR_OFF_RST      = 8'h08;
    localparam logic [7:0] SFR_OFF_MEM_MODE = 8'h0C;
    localparam logic [7:0] SFR_OFF_PROTECT  = 8'h18;

    // ==========================================================
    // Field codes
    localparam logic [3:0] SFR_PSIZE_NONE = 4'h0;
    localparam logic [3:0] SFR_PSIZE_32K  = 4'h3;
    localparam logic [3:0] SFR_PSIZE_64K  = 4'h5;
    localparam logic [3:0] SFR_PSIZE_128K = 4'h7;
    localparam logic [3:0] SFR_PSIZE_256K = 4'h9;
    localparam logic [3:0] SFR_DSIZE_NONE = 4'h0;
    localparam logic [3:0] SFR_VSIZE_NONE = 4'h0;
    localparam logic [3:0] SFR_VSIZE_1K   = 4'h1;
    localparam logic [3:0] SFR_VSIZE_2K   = 4'h2;
    localparam logic [3:0] SFR_VSIZE_4K   = 4'h4;
    localparam logic [3:0] SFR_VSIZE_8K   = 4'h8;

    localparam logic [7:0] SFR_CAUSE_PIN      = 8'h6C;
    localparam logic [7:0] SFR_CAUSE_WATCHDOG = 8'h53;

    localparam logic [15:0] SFR_PROTECT_KEY   = 16'h27A8;
    localparam int          SFR_KEY_LSB       = 16;
    localparam int          SFR_PROTECT_BIT   = 5;
    localparam int          SFR_PERMIT_BIT    = 0;
    localparam logic        SFR_PERMIT_RESET  = 1'b0;
    localparam logic        SFR_PROTECT_RESET = 1'b0;
    localparam logic [1:0]  SFR_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  SFR_RESP_SLVERR   = 2'h2;
    localparam logic [4:0]  SFR_VERSION_MAX   = 5'h1F;
    // Series codes for the memory type field; the values are arbitrary
    localparam logic [2:0]  SFR_TYPE_SERIES_A = 3'h2;
    localparam logic [2:0]  SFR_TYPE_SERIES_B = 3'h5;

    // ==========================================================
    // Identification word layout, bit 31 downward
    typedef struct packed {
        logic       id_extension_flag;
        logic [2:0] program_memory_type;
        logic [7:0] architecture_code;
        logic [3:0] volatile_ram_size;
        logic [3:0] data_nvm_size;
        logic [3:0] program_nvm_size;
        logic [2:0] fixed_pattern;
        logic [4:0] version;
    } sfr_chip_id_t;

    localparam logic [2:0] SFR_ID_PATTERN = 3'h2;

    // Read response carrier
    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } sfr_rd_t;

    typedef enum logic [1:0] {
        SFR_CAUSE_SEL_PIN,
        SFR_CAUSE_SEL_WATCHDOG,
        SFR_CAUSE_SEL_NONE
    } sfr_cause_sel_t;

endpackage

// file: sfr_decode.sv
// Read decoder of the special function register bank
`timescale 1ns/1ps
module sfr_decode (
    input  wire logic [7:0]           addr,
    input  wire sfr_pkg::sfr_chip_id_t chip_id,
    input  wire logic [31:0]          id_ext,
    input  wire logic [7:0]           cause,
    input  wire logic                 permit,
    input  wire logic                 protect,
    input  wire logic                 has_ext_ram,
    output sfr_pkg::sfr_rd_t          rd
);
    import sfr_pkg::*;

    // ==========================================================
    // Read mux; reserved bits and key field read as zero
    always_comb begin
        rd = '{data: 32'h0000_0000, resp: SFR_RESP_OKAY};
        case (addr)
            SFR_OFF_CHIP_ID:  rd.data = chip_id;
            SFR_OFF_ID_EXT:   rd.data = id_ext;                           // R7
            SFR_OFF_RST:      rd.data = {24'h000000, cause};             // R14
            SFR_OFF_MEM_MODE: begin
                if (has_ext_ram) begin
                    rd.data[SFR_PERMIT_BIT] = permit;                     // R12
                end else begin
                    rd.resp = SFR_RESP_SLVERR;
                end
            end
            SFR_OFF_PROTECT:  rd.data[SFR_PROTECT_BIT] = protect;         // R10
            default:          rd.resp = SFR_RESP_SLVERR;
        endcase
    end
endmodule

// file: sfr_bank_monitor.sv
// Port-level assertions for the special function register bank
`timescale 1ns/1ps
module sfr_bank_monitor (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        watchdog_reset,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        ram_write_req,
    input wire logic        ram_write_abort,
    input wire logic        irq_controller_protect
);
    import sfr_pkg::*;
    // ==========================================================
    // Address of the read in flight
    logic [7:0] rd_addr_d;
    logic [7:0] rd_addr_q;
    always_comb begin
        rd_addr_d = rd_addr_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_d = s_axi_araddr;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_addr_q <= 8'hFF;
        end else begin
            rd_addr_q <= rd_addr_d;
        end
    end
    // ==========================================================
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_abort_cause: assert property (ram_write_abort |-> ram_write_req)
        else $error("abort without a RAM write");
    a_protect_write: assert property ($changed(irq_controller_protect) |-> $rose(s_axi_bvalid))
        else $error("protect bit moved outside a write");
    a_protect_read: assert property (s_axi_rvalid && rd_addr_q == SFR_OFF_PROTECT
        |-> s_axi_rdata == {26'h0, irq_controller_protect, 5'h00}) else $error("protect readback");
    a_cause_code: assert property (s_axi_rvalid && rd_addr_q == SFR_OFF_RST
        |-> s_axi_rdata inside {32'h6C, 32'h53}) else $error("bad reset cause");
    a_mode_bits: assert property (s_axi_rvalid && rd_addr_q == SFR_OFF_MEM_MODE
        |-> s_axi_rdata[31:1] == 31'h0) else $error("memory mode reserved bits");
    a_id_fixed: assert property (s_axi_rvalid && rd_addr_q == SFR_OFF_CHIP_ID
        |-> s_axi_rdata[15:12] == 4'h0 && s_axi_rdata[7:5] == SFR_ID_PATTERN)
        else $error("chip id fixed fields");
    a_hole_error: assert property (s_axi_rvalid && rd_addr_q inside {8'h10, 8'h14}
        |-> s_axi_rresp == SFR_RESP_SLVERR) else $error("unmapped read not refused");
    a_read_delay: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_delay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule

// file: sfr_bank_bench.sv
// Self-checking bench for the special function register bank
`timescale 1ns/1ps
module sfr_bank_bench;
    import sfr_pkg::*;
    localparam logic [7:0]  ARCHITECTURE_CODE   = 8'h37;
    localparam logic [4:0]  VER    = 5'h1F;
    localparam logic [31:0] ID_EXP = {4'h0, ARCHITECTURE_CODE, SFR_VSIZE_2K, SFR_DSIZE_NONE,
                                      SFR_PSIZE_256K, SFR_ID_PATTERN, VER};
    logic sys_clk = 0, rst = 1, watchdog_reset = 0, ram_write_req = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, ram_write_abort, irq_controller_protect;
    int n_mismatch = 0, n_compared = 0, cycles = 0;

    sfr_bank #(.ARCHITECTURE_CODE_CODE(ARCHITECTURE_CODE), .PROG_SIZE(SFR_PSIZE_256K), .RAM_SIZE(SFR_VSIZE_2K),
        .VERSION(VER), .ID_EXTENDED(1'b0), .ID_EXT_WORD(32'h0), .HAS_EXT_RAM(1'b1)) dut (
        .sys_clk(sys_clk), .rst(rst), .watchdog_reset(watchdog_reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ram_write_req(ram_write_req),
        .ram_write_abort(ram_write_abort), .irq_controller_protect(irq_controller_protect));

    // ==========================================================
    // Clock, timeout and verdict
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // ==========================================================
    // Bus and reset tasks; the bus tasks return one edge after their handshake, the reset task four edges after release
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        check(s_axi_bresp, er, "write response");
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        check(s_axi_rdata & m, e, "read data");
        check(s_axi_rresp, er, "read response");
        @(posedge sys_clk);
    endtask
    // Watchdog level must outlast the release so the synchroniser sees it
    task automatic do_reset(input logic wd);
        watchdog_reset <= wd; rst <= 1;
        repeat (4) @(posedge sys_clk);
        rst <= 0;
        repeat (4) @(posedge sys_clk);
        watchdog_reset <= 0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_ident();
        rd(SFR_OFF_CHIP_ID, 32'h8FFF_FFFF, ID_EXP, SFR_RESP_OKAY);
        rd(SFR_OFF_CHIP_ID, 32'h7000_0000, {1'b0, SFR_TYPE_SERIES_A, 28'h0}, SFR_RESP_OKAY);
        rd(SFR_OFF_ID_EXT, '1, 32'h0, SFR_RESP_OKAY);
        wr(SFR_OFF_CHIP_ID, '1, 4'hF, SFR_RESP_OKAY);
        wr(SFR_OFF_ID_EXT, '1, 4'hF, SFR_RESP_OKAY);
        rd(SFR_OFF_CHIP_ID, 32'h8FFF_FFFF, ID_EXP, SFR_RESP_OKAY);
        rd(SFR_OFF_ID_EXT, '1, 32'h0, SFR_RESP_OKAY);
    endtask
    task automatic t_cause(input logic [7:0] code);
        rd(SFR_OFF_RST, '1, {24'h0, code}, SFR_RESP_OKAY);
        wr(SFR_OFF_RST, 32'hFF, 4'hF, SFR_RESP_OKAY);
        rd(SFR_OFF_RST, '1, {24'h0, code}, SFR_RESP_OKAY);
    endtask
    task automatic t_holes();
        rd(8'h10, 32'h0, 32'h0, SFR_RESP_SLVERR);
        rd(8'h14, 32'h0, 32'h0, SFR_RESP_SLVERR);
        wr(8'h14, '1, 4'hF, SFR_RESP_SLVERR);
    endtask
    task automatic t_mode();
        ram_write_req <= 1;
        @(posedge sys_clk);
        check(ram_write_abort, 1, "abort while locked");
        rd(SFR_OFF_MEM_MODE, '1, 32'h0, SFR_RESP_OKAY);
        wr(SFR_OFF_MEM_MODE, '1, 4'hF, SFR_RESP_OKAY);
        rd(SFR_OFF_MEM_MODE, '1, 32'h1, SFR_RESP_OKAY);
        check(ram_write_abort, 0, "write allowed");
        wr(SFR_OFF_MEM_MODE, 32'h0, 4'hE, SFR_RESP_OKAY);
        rd(SFR_OFF_MEM_MODE, '1, 32'h1, SFR_RESP_OKAY);
        wr(SFR_OFF_MEM_MODE, 32'h0, 4'h1, SFR_RESP_OKAY);
        check(ram_write_abort, 1, "write locked again");
    endtask
    task automatic t_protect();
        rd(SFR_OFF_PROTECT, '1, 32'h0, SFR_RESP_OKAY);
        wr(SFR_OFF_PROTECT, {16'h27A9, 16'h0020}, 4'hF, SFR_RESP_OKAY);
        check(irq_controller_protect, 0, "wrong key");
        wr(SFR_OFF_PROTECT, {SFR_PROTECT_KEY, 16'h0020}, 4'hF, SFR_RESP_OKAY);
        check(irq_controller_protect, 1, "right key");
        rd(SFR_OFF_PROTECT, '1, 32'h20, SFR_RESP_OKAY);
        wr(SFR_OFF_PROTECT, {SFR_PROTECT_KEY, 16'h0000}, 4'h7, SFR_RESP_OKAY);
        check(irq_controller_protect, 1, "key lane missing");
    endtask
    // Mid-run resets: watchdog then pin, with state set beforehand
    task automatic t_resets();
        wr(SFR_OFF_MEM_MODE, 32'h1, 4'h1, SFR_RESP_OKAY);
        do_reset(1);
        check(irq_controller_protect, 0, "protect after reset");
        check(ram_write_abort, 1, "permit after reset");
        t_cause(SFR_CAUSE_WATCHDOG);
        do_reset(0);
        t_cause(SFR_CAUSE_PIN);
    endtask

    initial begin
        do_reset(0);
        t_ident();
        t_cause(SFR_CAUSE_PIN);
        t_holes();
        t_mode();
        t_protect();
        t_resets();
        end_of_test();
    end
endmodule

bind sfr_bank sfr_bank_monitor mon (.sys_clk(sys_clk), .rst(rst),
    .watchdog_reset(watchdog_reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ram_write_req(ram_write_req), .ram_write_abort(ram_write_abort),
    .irq_controller_protect(irq_controller_protect));
